/* File: tbio_pkg.sv */
// constants shared by the register io control block
package tbio_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] OFS_CTL1 = 8'h00;
  localparam logic [7:0] OFS_CTL2 = 8'h04;
  localparam logic [7:0] OFS_CTL3 = 8'h08;
  localparam logic [7:0] OFS_GB1 = 8'h0c;
  localparam logic [7:0] OFS_GB2 = 8'h10;
  localparam logic [7:0] OFS_GB3 = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1c;
  localparam int ADDR_W = 8;

  // reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;

  // function field sits in bits 7..4 of each control register
  localparam int FUNC_LSB = 4;
  localparam int FUNC_W = 4;
  localparam int FUNC_CAP_BIT = 3; // 1: capture register
  localparam int FUNC_SRC_BIT = 2; // capture: cascade; compare: init level

  // compare pin actions, low two bits of the function field
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;

  // pin capture edges, low two bits in capture mode (1x is both)
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  // status/mask layout: capture flags low, match flags high
  localparam int STAT_CAP_LSB = 0;
  localparam int STAT_MATCH_LSB = 4;
  localparam int NCHAN = 3;

  // undivided prescaler selection of the neighbour counter
  localparam logic [2:0] PRESCALE_DIRECT = 3'h0;

  // cascade kinds of a channel
  localparam int KIND_PIN_ONLY = 0;
  localparam int KIND_NEIGHBOUR_MATCH = 1;
  localparam int KIND_NEIGHBOUR_COUNT = 3;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // true when the function field selects a capture register
  function automatic logic is_capture(input logic [3:0] func);
    return func[FUNC_CAP_BIT];
  endfunction
endpackage

/* File: tbio_chan.sv */
// one channel: general register b with its compare and capture logic
`timescale 1ns/1ps
`default_nettype none
module tbio_chan #(
  parameter int CW = 16,
  parameter int KIND = 0
)(
  input wire logic aclk, // peripheral clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic [3:0] func, // function field of the control register
  input wire logic [CW-1:0] counter, // channel counter value
  input wire logic counter_run, // channel counter is counting
  input wire logic pin_in, // channel pin level
  input wire logic casc_evt, // cascaded capture event from neighbour
  input wire logic gb_wr, // software write of general register b
  input wire logic [CW-1:0] gb_wdata, // software write data
  output logic [CW-1:0] gb_q, // general register b
  output logic pin_out_q, // pin output level
  output logic pin_oe_q, // pin output enable
  output logic cap_q, // capture happened, one cycle
  output logic match_q // compare match happened, one cycle
);
  generate
    if (CW < 1 || CW > 32)
    begin : g_bad
      $error("counter width must be 1 to 32");
    end
  endgenerate

  logic pin_prev_q;
  logic cap_mode;
  logic casc_sel;
  logic rise;
  logic fall;
  logic pin_evt;
  logic cap_evt;
  logic match_now;

  // decode; channel 2 ignores the source bit so only the pin captures
  assign cap_mode = tbio_pkg::is_capture(func);
  assign casc_sel = cap_mode && func[tbio_pkg::FUNC_SRC_BIT] &&
                    (KIND != tbio_pkg::KIND_PIN_ONLY);
  assign rise = pin_in && !pin_prev_q;
  assign fall = !pin_in && pin_prev_q;
  assign pin_evt = (func[1:0] == tbio_pkg::EDGE_RISE) ? rise :
                   (func[1:0] == tbio_pkg::EDGE_FALL) ? fall :
                   (rise || fall);
  assign cap_evt = cap_mode && (casc_sel ? casc_evt : pin_evt);
  assign match_now = !cap_mode && counter_run && (counter == gb_q);

  // previous pin level for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_prev_q <= 1'b0;
    else
      pin_prev_q <= pin_in;
  end

  // capture beats a software write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      gb_q <= '0;
    else if (cap_evt)
      gb_q <= counter;
    else if (gb_wr)
      gb_q <= gb_wdata;
  end

  // pin level: initial level while stopped, actions on match
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_out_q <= 1'b0;
    else if (!cap_mode && !counter_run)
      pin_out_q <= func[tbio_pkg::FUNC_SRC_BIT];
    else if (match_now)
    begin
      case (func[1:0])
        tbio_pkg::ACT_LOW: pin_out_q <= 1'b0;
        tbio_pkg::ACT_HIGH: pin_out_q <= 1'b1;
        tbio_pkg::ACT_TOGGLE: pin_out_q <= !pin_out_q;
        default: pin_out_q <= pin_out_q;
      endcase
    end
  end

  // capture codes leave the pin to the outside world
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_oe_q <= 1'b0;
    else
      pin_oe_q <= !cap_mode && (func[1:0] != tbio_pkg::ACT_OFF);
  end

  // event pulses for the status register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cap_q <= 1'b0;
      match_q <= 1'b0;
    end
    else
    begin
      cap_q <= cap_evt;
      match_q <= match_now;
    end
  end

  match_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    match_now && func[1:0] == 2'h1 |=> !pin_out_q)
    else $error("low action on match failed");
  match_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    match_now && func[1:0] == 2'h2 |=> pin_out_q)
    else $error("high action on match failed");
  match_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    match_now && func[1:0] == 2'h3 |=> pin_out_q != $past(pin_out_q))
    else $error("toggle on match failed");
  init_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !func[3] && !counter_run |=> pin_out_q == $past(func[2]))
    else $error("initial level not driven while stopped");
  rise_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    func == 4'h8 && pin_in && !pin_prev_q |=> gb_q == $past(counter) && cap_q)
    else $error("rising edge capture missed");
  fall_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    func == 4'h9 && !pin_in && pin_prev_q |=> gb_q == $past(counter))
    else $error("falling edge capture missed");
  both_cap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    func[3:1] == 3'h5 && pin_in != pin_prev_q |=> cap_q)
    else $error("both edge capture missed");
  cap_no_drive_a: assert property (@(posedge aclk)
    disable iff (!aresetn) func[3] ##1 func[3] |-> !pin_oe_q)
    else $error("pin driven in capture mode");
endmodule
`default_nettype wire

/* File: tbio_top.sv */
// io control of general register b for channels 1 to 3, axi4-lite slave
//
// Behaviour
// - codes 0001/0101: compare register, pin goes low on each match.
// - codes 0010/0110: pin goes high on each compare match.
// - codes 0011/0111: pin toggles on each compare match.
// - bit 6 picks initial level; x000 disables output; reset is all zero.
// - code 1000 captures on rising pin edge; channel 2 ignores bit 6.
// - code 1001 captures counter on falling pin edge.
// - codes 101x capture on both pin edges.
// - channel 1 codes 11xx capture on channel 0 register c match/capture.
// - channel 3 codes 11xx capture on channel 4 count up or down.
// - channel 4 prescaler 000 makes channel 3 cascaded capture do nothing.
// - initial level is driven onto the pin only while counter stopped.
// - all control registers clear to zero on reset and hardware standby.
`timescale 1ns/1ps
`default_nettype none
module tbio_top #(
  parameter int CW = 16
)(
  input wire logic aclk, // 10 mhz peripheral clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic hw_standby, // hardware standby, clears controls
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic irq_q, // level interrupt
  input wire logic [CW-1:0] chan1_counter, // channel 1 counter
  input wire logic [CW-1:0] chan2_counter, // channel 2 counter
  input wire logic [CW-1:0] chan3_counter, // channel 3 counter
  input wire logic [2:0] counter_run, // counter running, one per channel
  input wire logic chan1_pin_b_in, // channel 1 pin level
  output logic chan1_pin_b_out, // channel 1 pin drive level
  output logic chan1_pin_b_oe, // channel 1 pin drive enable
  input wire logic chan2_pin_b_in, // channel 2 pin level
  output logic chan2_pin_b_out, // channel 2 pin drive level
  output logic chan2_pin_b_oe, // channel 2 pin drive enable
  input wire logic chan3_pin_b_in, // channel 3 pin level
  output logic chan3_pin_b_out, // channel 3 pin drive level
  output logic chan3_pin_b_oe, // channel 3 pin drive enable
  input wire logic chan0_general_c_evt, // ch0 reg c match or capture pulse
  input wire logic chan4_count_up, // channel 4 counter counted up
  input wire logic chan4_count_down, // channel 4 counter counted down
  input wire logic [2:0] chan4_prescale_sel // channel 4 prescaler selection
);
  generate
    if (CW < 1 || CW > 32)
    begin : g_bad
      $error("counter width must be 1 to 32");
    end
  endgenerate

  logic [7:0] chan1_io_control_q;
  logic [7:0] chan2_io_control_q;
  logic [7:0] chan3_io_control_high_q;
  logic [7:0] stat_q;
  logic [7:0] mask_q;
  logic [7:0] aw_addr_q;
  logic aw_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_full_q;
  logic do_write;
  logic do_read;
  logic [CW-1:0] gb1;
  logic [CW-1:0] gb2;
  logic [CW-1:0] gb3;
  logic [2:0] cap;
  logic [2:0] match;
  logic [2:0] gb_wr;
  logic [CW-1:0] gb_wdata;
  logic casc3_evt;
  logic [7:0] stat_set;
  logic stat_rd;
  logic [31:0] rd_word;
  logic rd_hit;

  // byte lane merge for the narrow registers
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] d,
                                       input logic [3:0] s);
    return s[0] ? d[7:0] : old;
  endfunction

  // address hit test for the write response; the read mux decodes on its own
  function automatic logic is_mapped(input logic [7:0] a);
    return a == tbio_pkg::OFS_CTL1 || a == tbio_pkg::OFS_CTL2 ||
           a == tbio_pkg::OFS_CTL3 || a == tbio_pkg::OFS_GB1 ||
           a == tbio_pkg::OFS_GB2 || a == tbio_pkg::OFS_GB3 ||
           a == tbio_pkg::OFS_STAT || a == tbio_pkg::OFS_MASK;
  endfunction

  // write fires once address and data are both held
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  // write address channel; ready stays low until the response is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      s_axi_awready <= 1'b1;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end
    else if (do_write)
      aw_full_q <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  // write data channel, independent of the address channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end
    else if (do_write)
      w_full_q <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tbio_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr_q) ? tbio_pkg::RESP_OKAY :
                     tbio_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // control registers; standby wipes them like a reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn || hw_standby)
    begin
      chan1_io_control_q <= tbio_pkg::CTL_RESET;
      chan2_io_control_q <= tbio_pkg::CTL_RESET;
      chan3_io_control_high_q <= tbio_pkg::CTL_RESET;
    end
    else if (do_write)
    begin
      if (aw_addr_q == tbio_pkg::OFS_CTL1)
        chan1_io_control_q <= lane0(chan1_io_control_q, w_data_q, w_strb_q);
      if (aw_addr_q == tbio_pkg::OFS_CTL2)
        chan2_io_control_q <= lane0(chan2_io_control_q, w_data_q, w_strb_q);
      if (aw_addr_q == tbio_pkg::OFS_CTL3)
        chan3_io_control_high_q <= lane0(chan3_io_control_high_q,
                                         w_data_q, w_strb_q);
    end
  end

  // mask register, same layout as status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      mask_q <= tbio_pkg::IRQ_RESET;
    else if (do_write && aw_addr_q == tbio_pkg::OFS_MASK)
      mask_q <= lane0(mask_q, w_data_q, w_strb_q);
  end

  // general register writes; whole word, strobes ignored for simplicity
  assign gb_wdata = w_data_q[CW-1:0];
  assign gb_wr[0] = do_write && aw_addr_q == tbio_pkg::OFS_GB1;
  assign gb_wr[1] = do_write && aw_addr_q == tbio_pkg::OFS_GB2;
  assign gb_wr[2] = do_write && aw_addr_q == tbio_pkg::OFS_GB3;

  // neighbour count at the undivided clock cannot be captured in time
  assign casc3_evt = (chan4_count_up || chan4_count_down) &&
    (chan4_prescale_sel != tbio_pkg::PRESCALE_DIRECT);

  tbio_chan #(.CW(CW), .KIND(tbio_pkg::KIND_NEIGHBOUR_MATCH)) u_chan1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .func(chan1_io_control_q[7:4]),
    .counter(chan1_counter),
    .counter_run(counter_run[0]),
    .pin_in(chan1_pin_b_in),
    .casc_evt(chan0_general_c_evt),
    .gb_wr(gb_wr[0]),
    .gb_wdata(gb_wdata),
    .gb_q(gb1),
    .pin_out_q(chan1_pin_b_out),
    .pin_oe_q(chan1_pin_b_oe),
    .cap_q(cap[0]),
    .match_q(match[0])
  );

  tbio_chan #(.CW(CW), .KIND(tbio_pkg::KIND_PIN_ONLY)) u_chan2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .func(chan2_io_control_q[7:4]),
    .counter(chan2_counter),
    .counter_run(counter_run[1]),
    .pin_in(chan2_pin_b_in),
    .casc_evt(1'b0),
    .gb_wr(gb_wr[1]),
    .gb_wdata(gb_wdata),
    .gb_q(gb2),
    .pin_out_q(chan2_pin_b_out),
    .pin_oe_q(chan2_pin_b_oe),
    .cap_q(cap[1]),
    .match_q(match[1])
  );

  tbio_chan #(.CW(CW), .KIND(tbio_pkg::KIND_NEIGHBOUR_COUNT)) u_chan3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .func(chan3_io_control_high_q[7:4]),
    .counter(chan3_counter),
    .counter_run(counter_run[2]),
    .pin_in(chan3_pin_b_in),
    .casc_evt(casc3_evt),
    .gb_wr(gb_wr[2]),
    .gb_wdata(gb_wdata),
    .gb_q(gb3),
    .pin_out_q(chan3_pin_b_out),
    .pin_oe_q(chan3_pin_b_oe),
    .cap_q(cap[2]),
    .match_q(match[2])
  );

  // sticky events; a set in the clearing read cycle survives
  assign stat_set = {1'b0, match, 1'b0, cap};
  assign stat_rd = do_read && s_axi_araddr == tbio_pkg::OFS_STAT;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= tbio_pkg::IRQ_RESET;
    else if (stat_rd)
      stat_q <= stat_set;
    else
      stat_q <= stat_q | stat_set;
  end

  // interrupt level from the registered status and mask
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_q <= 1'b0;
    else
      irq_q <= |(stat_q & mask_q);
  end

  // read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      tbio_pkg::OFS_CTL1: rd_word[7:0] = chan1_io_control_q;
      tbio_pkg::OFS_CTL2: rd_word[7:0] = chan2_io_control_q;
      tbio_pkg::OFS_CTL3: rd_word[7:0] = chan3_io_control_high_q;
      tbio_pkg::OFS_GB1: rd_word[CW-1:0] = gb1;
      tbio_pkg::OFS_GB2: rd_word[CW-1:0] = gb2;
      tbio_pkg::OFS_GB3: rd_word[CW-1:0] = gb3;
      tbio_pkg::OFS_STAT: rd_word[7:0] = stat_q;
      tbio_pkg::OFS_MASK: rd_word[7:0] = mask_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel: one read at a time, answer one cycle after the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= tbio_pkg::RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? tbio_pkg::RESP_OKAY : tbio_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  standby_clear_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    hw_standby |=> chan1_io_control_q == 8'h00 &&
      chan2_io_control_q == 8'h00 && chan3_io_control_high_q == 8'h00)
    else $error("controls not cleared in standby");
  direct_clock_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    chan3_io_control_high_q[7:6] == 2'h3 && chan4_prescale_sel == 3'h0
    |=> !cap[2])
    else $error("capture with undivided neighbour clock");
  chan4_cascade_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    chan3_io_control_high_q[7:6] == 2'h3 && chan4_prescale_sel != 3'h0 &&
    (chan4_count_up || chan4_count_down)
    |=> cap[2] && gb3 == $past(chan3_counter))
    else $error("neighbour count capture missed");
  chan0_cascade_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    chan1_io_control_q[7:6] == 2'h3 && chan0_general_c_evt
    |=> cap[0] && gb1 == $past(chan1_counter))
    else $error("neighbour match capture missed");
  chan2_pin_only_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    chan2_io_control_q[7:4] == 4'hc && chan2_pin_b_in == u_chan2.pin_prev_q
    |=> !cap[1])
    else $error("channel 2 captured without a pin edge");
  disabled_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
    chan1_io_control_q[7:4] == 4'h0 ##1 chan1_io_control_q[7:4] == 4'h0
    |-> !chan1_pin_b_oe)
    else $error("pin driven while output disabled");
endmodule
`default_nettype wire

/* File: tbio_far.sv */
// far side model: channel pins shared with an outside driver
`timescale 1ns/1ps
`default_nettype none
module tbio_far (
  input wire logic [2:0] drv_lvl, // design pin drive levels
  input wire logic [2:0] drv_en, // design pin drive enables
  input wire logic [2:0] ext_lvl, // level offered by the outside world
  output logic [2:0] pin // resolved pin level
);
  // design wins only where it enables; capture leaves the pin outside
  assign pin = (drv_en & drv_lvl) | (~drv_en & ext_lvl);
endmodule
`default_nettype wire

/* File: timer_b_register_io_control_test.sv */
// bench for the general register b io control block
`timescale 1ns/1ps
`default_nettype none
module timer_b_register_io_control_test;
  // rows: function code, initial level, level after one match, enable
  localparam logic [6:0] ROWS [8] = '{7'h09, 7'h13, 7'h1b, 7'h2d, 7'h37,
    7'h3d, 7'h00, 7'h26};
  localparam logic [3:0] CAPS [4] = '{4'h8, 4'h9, 4'ha, 4'hc};
  logic aclk = 1'b0, aresetn = 1'b0, hw_standby = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic c_evt = 1'b0, up = 1'b0, down = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [15:0] cnt1 = 16'h0, cnt2 = 16'h0, cnt3 = 16'h0;
  logic [2:0] run = 3'h0, psel = 3'h0, ext = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rdat;
  logic [2:0] pout, poe, pin;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #50 aclk = ~aclk;

  tbio_top #(.CW(16)) i_tbio_top (.aclk(aclk), .aresetn(aresetn),
    .hw_standby(hw_standby), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq_q(irq), .chan1_counter(cnt1),
    .chan2_counter(cnt2), .chan3_counter(cnt3), .counter_run(run),
    .chan1_pin_b_in(pin[0]), .chan1_pin_b_out(pout[0]),
    .chan1_pin_b_oe(poe[0]), .chan2_pin_b_in(pin[1]),
    .chan2_pin_b_out(pout[1]), .chan2_pin_b_oe(poe[1]),
    .chan3_pin_b_in(pin[2]), .chan3_pin_b_out(pout[2]),
    .chan3_pin_b_oe(poe[2]), .chan0_general_c_evt(c_evt),
    .chan4_count_up(up), .chan4_count_down(down),
    .chan4_prescale_sel(psel));

  tbio_far i_tbio_far (.drv_lvl(pout), .drv_en(poe), .ext_lvl(ext),
    .pin(pin));

  // verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // compare one value and count it
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!(bready && bvalid));
    bready <= 1'b0;
    resp = bresp;
  endtask

  // axi4-lite read, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!(rready && rvalid));
    rready <= 1'b0;
    rdat = rdata;
    resp = rresp;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      n_errors++;
      results();
    end
  end

  // main sequence
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rd(8'(i * 4));
      chk(rdat, 32'h0);
    end
    chk(32'(poe), 32'h0);
    rd(8'h20);
    chk(32'(resp), 32'(tbio_pkg::RESP_SLVERR));
    wr(8'h20, 32'hff);
    chk(32'(resp), 32'(tbio_pkg::RESP_SLVERR));
    chk(rdat, 32'h0);
    $display("reset test done");
    wr(tbio_pkg::OFS_GB1, 32'h5);
    chk(32'(resp), 32'(tbio_pkg::RESP_OKAY));
    foreach (ROWS[i])
    begin
      wr(tbio_pkg::OFS_CTL1, {24'h0, ROWS[i][6:3], 4'h0});
      repeat (3) @(posedge aclk);
      chk(32'(pout[0]), 32'(ROWS[i][2]));
      chk(32'(poe[0]), 32'(ROWS[i][0]));
      cnt1 <= 16'h0005;
      run <= 3'h1;
      @(posedge aclk);
      cnt1 <= 16'h0006;
      repeat (3) @(posedge aclk);
      chk(32'(pout[0]), 32'(ROWS[i][1]));
      run <= 3'h0;
      cnt1 <= 16'h0000;
    end
    // channels 2 and 3 as stopped compare registers, levels and enables
    wr(tbio_pkg::OFS_CTL2, 32'h20);
    wr(tbio_pkg::OFS_CTL3, 32'h50);
    repeat (3) @(posedge aclk);
    chk(32'({pout[2:1], poe[2:1]}), 32'hb);
    $display("compare test done");
    foreach (CAPS[i])
    begin
      wr(tbio_pkg::OFS_GB2, 32'h0);
      wr(tbio_pkg::OFS_CTL2, {24'h0, CAPS[i], 4'h0});
      @(posedge aclk);
      cnt2 <= 16'h1234;
      ext[1] <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(tbio_pkg::OFS_GB2);
      chk(rdat, CAPS[i][1:0] == 2'h1 ? 32'h0 : 32'h1234);
      cnt2 <= 16'habcd;
      ext[1] <= 1'b0;
      repeat (4) @(posedge aclk);
      rd(tbio_pkg::OFS_GB2);
      chk(rdat, CAPS[i][1:0] == 2'h0 ? 32'h1234 : 32'habcd);
      chk(32'(poe[1]), 32'h0);
    end
    $display("pin capture test done");
    rd(tbio_pkg::OFS_STAT);
    chk(rdat, 32'h12);
    wr(tbio_pkg::OFS_CTL1, 32'hc0);
    cnt1 <= 16'h0042;
    c_evt <= 1'b1;
    @(posedge aclk);
    c_evt <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(32'(irq), 32'h0);
    rd(tbio_pkg::OFS_GB1);
    chk(rdat, 32'h42);
    wr(tbio_pkg::OFS_MASK, 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h1);
    rd(tbio_pkg::OFS_STAT);
    chk(rdat, 32'h1);
    repeat (3) @(posedge aclk);
    chk(32'(irq), 32'h0);
    $display("channel 1 cascade and interrupt test done");
    wr(tbio_pkg::OFS_CTL3, 32'hc0);
    cnt3 <= 16'h0077;
    up <= 1'b1;
    @(posedge aclk);
    up <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(tbio_pkg::OFS_GB3);
    chk(rdat, 32'h0);
    psel <= 3'h1;
    down <= 1'b1;
    @(posedge aclk);
    down <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(tbio_pkg::OFS_GB3);
    chk(rdat, 32'h77);
    $display("channel 3 cascade test done");
    hw_standby <= 1'b1;
    @(posedge aclk);
    hw_standby <= 1'b0;
    rd(tbio_pkg::OFS_CTL3);
    chk(rdat, 32'h0);
    rd(tbio_pkg::OFS_CTL1);
    chk(rdat, 32'h0);
    $display("standby test done");
    results();
  end
endmodule
`default_nettype wire
